/* File: gppc_port_cfg.svh */
// constants of the pin port: offsets, fields, defaults and timing
`ifndef GPPC_PORT_CFG_SVH
`define GPPC_PORT_CFG_SVH

// ==========================================
// timing
`define GPPC_CLK_HZ 40000000
`define GPPC_PWM_HZ 100
`define GPPC_PWM_STEPS 100
`define GPPC_SAMPLE_HZ 32
`define GPPC_STEP_CYC (`GPPC_CLK_HZ / (`GPPC_PWM_HZ * `GPPC_PWM_STEPS))
`define GPPC_SAMPLE_CYC (`GPPC_CLK_HZ / `GPPC_SAMPLE_HZ)

// ==========================================
// pins
`define GPPC_NPIN 5
`define GPPC_NPIN_B 8'h05

// ==========================================
// register offsets (byte addresses)
`define GPPC_OFS_PARAM 8'h00
`define GPPC_OFS_CMD 8'h04
`define GPPC_OFS_RESP 8'h08
`define GPPC_OFS_PIN0 8'h10

// ==========================================
// packet codes and limits
`define GPPC_CMD_GPIO 8'h22
`define GPPC_CMD_STORE 8'h04
`define GPPC_ACK_BIT 8'h40
`define GPPC_ERR_BITS 8'hc0
`define GPPC_LEN_VAL 8'h02
`define GPPC_LEN_FULL 8'h03
`define GPPC_LEN_NONE 8'h00
`define GPPC_VAL_HIGH 8'h64
`define GPPC_FM_MAX 8'h0f

// ==========================================
// field positions
`define GPPC_ST_LEVEL 0
`define GPPC_ST_FALL 1
`define GPPC_ST_RISE 2
`define GPPC_RESP_ERR 16
`define GPPC_FM_FUNC 3

// ==========================================
// factory defaults, pin 4 in the top byte
`define GPPC_DEF_VAL 40'h64_00_00_00_00
`define GPPC_DEF_FM 40'h07_02_02_03_02

`endif

/* File: gppc_pkg.sv */
// types shared by the pin port modules
package gppc_pkg;

  // ==========================================
  // drive modes of the three-bit drive_mode_field
  typedef enum logic [2:0] {
    GPPC_M_UP_PD = 3'b000,
    GPPC_M_PUSH_FAST = 3'b001,
    GPPC_M_HIZ = 3'b010,
    GPPC_M_PU_DN = 3'b011,
    GPPC_M_UP_HIZ = 3'b100,
    GPPC_M_PUSH_SLOW = 3'b101,
    GPPC_M_RSVD = 3'b110,
    GPPC_M_OPEN_DRAIN = 3'b111
  } gppc_mode_t;

  // per-pin pad control: {out, oe_n, pull_up, pull_dn, slow}
  typedef logic [4:0] gppc_pad_t;

endpackage

/* File: gppc_pwm.sv */
// shared 100 Hz pwm timebase and per-pin duty compare
`timescale 1ns/100ps
`include "gppc_port_cfg.svh"

module gppc_pwm (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [39:0] duty,
  output logic [4:0] pwm_level
);

  localparam logic [11:0] STEP_LAST = 12'(`GPPC_STEP_CYC - 1);
  localparam logic [6:0] PHASE_LAST = 7'(`GPPC_PWM_STEPS - 1);

  logic [11:0] step_r;
  logic [6:0] phase_r;
  wire step_tick = (step_r == STEP_LAST);

  // ==========================================
  // timebase: 100 phases of one percent each
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_r <= 12'h000;
      phase_r <= 7'h00;
    end else begin
      step_r <= step_tick ? 12'h000 : step_r + 12'h001;
      if (step_tick) begin
        phase_r <= (phase_r == PHASE_LAST) ? 7'h00 : phase_r + 7'h01;
      end
    end
  end

  // ==========================================
  // 0 stays low, 100 stays high, else duty percent
  genvar i;
  generate
    for (i = 0; i < `GPPC_NPIN; i++) begin : g_duty
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          pwm_level[i] <= 1'b0;
        end else begin
          pwm_level[i] <= ({1'b0, phase_r} < duty[8*i +: 8]); // RL2
        end
      end
    end
  endgenerate

endmodule

/* File: gppc_sampler.sv */
// 32 Hz input sampler with sticky rising and falling edge flags
`timescale 1ns/100ps
`include "gppc_port_cfg.svh"

module gppc_sampler #(
  parameter int unsigned SAMPLE_CYC = `GPPC_SAMPLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] pin_in,
  input wire logic [4:0] clr_edge,
  output logic [4:0] level,
  output logic [4:0] rise,
  output logic [4:0] fall
);

  localparam int CW = $clog2(SAMPLE_CYC + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(SAMPLE_CYC - 1);

  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [CW-1:0] div_r;
  logic primed_r;
  wire sample_tick = (div_r == DIV_LAST);

  // ==========================================
  // pins are asynchronous: two flops first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
      div_r <= '0;
      primed_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      div_r <= sample_tick ? '0 : div_r + CW'(1); // RL3
      // first sample only loads the level: a pin idling high shows no false rise
      if (sample_tick) begin
        primed_r <= 1'b1;
      end
    end
  end

  // ==========================================
  // only the slow samples are compared, so bounce between them is unseen
  genvar i;
  generate
    for (i = 0; i < `GPPC_NPIN; i++) begin : g_pin
      wire up_seen = sample_tick && primed_r && sync_r[i] && !level[i];
      wire dn_seen = sample_tick && primed_r && !sync_r[i] && level[i];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          level[i] <= 1'b0;
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
        end else begin
          if (sample_tick) begin
            level[i] <= sync_r[i]; // RL5
          end
          // a new edge beats a clear in the same cycle
          rise[i] <= up_seen | (rise[i] & ~clr_edge[i]); // RL4
          fall[i] <= dn_seen | (fall[i] & ~clr_edge[i]); // RL4
        end
      end
    end
  endgenerate

endmodule

/* File: gppc_port.sv */
// five-pin port with level/pwm outputs, drive modes and edge-latched inputs
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "gppc_port_cfg.svh"

// How it works
// RL1: five pins, each shared with a default alternate function.
// RL2: output is steady high, steady low, or 100 Hz pwm.
// RL3: every pin is sampled as input at 32 Hz regardless of output use.
// RL4: rising and falling edges of samples latch until the host reads.
// RL5: level comes from periodic samples, so it is debounced; short pulses lost.
// RL6: command 0x22 carries two bytes for value, three for full setup.
// RL7: first byte picks pin 0 to 4; other indices do nothing; the code refuses them with an error reply.
// RL8: value 0 low, 1-99 pwm percent, 100 high, rest invalid.
// RL9: third byte holds drive mode low, function bit above; max 15.
// RL10: modes 000, 001, 010 drive as tabled: pull-down, push-pull, hi-z.
// RL11: modes 011, 100, 101: pull-up/low, slow high/float, slow push-pull.
// RL12: mode 111 floats high and drives low slowly: open drain.
// RL13: reserved mode 110 is refused with an error reply.
// RL14: function 0 gives the pin to its alternate; 1 to the host value.
// RL15: a good command is acknowledged with type 0x62, no payload; the code acknowledges a store command with 0x44.
// RL16: reset values let the power-control and sensor-bus functions work.
// RL17: store command saves pin setup to boot state, restored after reset.
// RL18: pull-up with switch to ground reads 1 open, 0 closed.
// RL19: status reports sampled level, falling flag and rising flag.
// RL20: reading a pin status clears its edge flags.
// RL21: pwm high phases use the mode's high drive, low phases its low drive.
// RL22: a value-only command keeps function and drive mode.

module gppc_port #(
  parameter int unsigned SAMPLE_CYC = `GPPC_SAMPLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pwr_on_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [4:0] pin_in,
  input wire logic [4:0] alt_level,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n,
  output logic [4:0] pin_pull_up,
  output logic [4:0] pin_pull_dn,
  output logic [4:0] pin_slow,
  output logic [4:0] pin_level,
  output logic [4:0] pin_user
);

  localparam int NPIN = `GPPC_NPIN;
  localparam logic [39:0] DEF_VAL = `GPPC_DEF_VAL;
  localparam logic [39:0] DEF_FM = `GPPC_DEF_FM;

  // ==========================================
  // pad drive per mode and level
  function automatic gppc_pkg::gppc_pad_t pad_of(input logic [2:0] mode, input logic lvl);
    gppc_pkg::gppc_pad_t p;
    p = 5'b01000;
    case (gppc_pkg::gppc_mode_t'(mode))
      gppc_pkg::GPPC_M_UP_PD: p = lvl ? 5'b10000 : 5'b01010;
      gppc_pkg::GPPC_M_PUSH_FAST: p = {lvl, 4'b0000};
      gppc_pkg::GPPC_M_HIZ: p = 5'b01000;
      gppc_pkg::GPPC_M_PU_DN: p = lvl ? 5'b01100 : 5'b00000;
      gppc_pkg::GPPC_M_UP_HIZ: p = lvl ? 5'b10001 : 5'b01000;
      gppc_pkg::GPPC_M_PUSH_SLOW: p = {lvl, 4'b0001};
      gppc_pkg::GPPC_M_OPEN_DRAIN: p = lvl ? 5'b01000 : 5'b00001;
      default: p = 5'b01000;
    endcase
    return p;
  endfunction

  // ==========================================
  // state
  logic [31:0] param_r;
  logic [16:0] resp_r;
  logic restore_r;
  logic [7:0] val_r [NPIN];
  logic [3:0] fm_r [NPIN];
  logic [7:0] boot_val_r [NPIN];
  logic [3:0] boot_fm_r [NPIN];
  logic [39:0] duty;
  logic [4:0] pwm_level;
  logic [4:0] edge_rise;
  logic [4:0] edge_fall;
  logic [4:0] rd_pin_hit;
  logic [31:0] pin_word [NPIN];

  // ==========================================
  // command decode, acted on in the cycle of the write to the command register
  wire cmd_wr = bus_wr && (bus_addr == `GPPC_OFS_CMD);
  wire [7:0] cmd_type = bus_wdata[7:0];
  wire [7:0] cmd_len = bus_wdata[15:8];
  wire [7:0] arg_idx = param_r[7:0];
  wire [7:0] arg_val = param_r[15:8];
  wire [7:0] arg_fm = param_r[23:16];
  wire len_full = (cmd_len == `GPPC_LEN_FULL);
  wire len_ok = (cmd_len == `GPPC_LEN_VAL) || len_full; // RL6
  wire idx_ok = (arg_idx < `GPPC_NPIN_B); // RL7
  wire val_ok = (arg_val <= `GPPC_VAL_HIGH); // RL8
  wire fm_ok = !len_full ||
               ((arg_fm <= `GPPC_FM_MAX) && (arg_fm[2:0] != gppc_pkg::GPPC_M_RSVD)); // RL9 RL13
  wire gpio_ok = (cmd_type == `GPPC_CMD_GPIO) && len_ok && idx_ok && val_ok && fm_ok;
  wire store_ok = (cmd_type == `GPPC_CMD_STORE) && (cmd_len == `GPPC_LEN_NONE);
  wire cmd_good = gpio_ok || store_ok;
  wire apply = cmd_wr && gpio_ok && !restore_r;
  wire store = cmd_wr && store_ok && !restore_r; // RL17
  wire [7:0] reply_type = cmd_type | (cmd_good ? `GPPC_ACK_BIT : `GPPC_ERR_BITS); // RL15

  // ==========================================
  // software-facing registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      param_r <= 32'h0000_0000;
      resp_r <= 17'h0_0000;
      restore_r <= 1'b1;
    end else begin
      restore_r <= 1'b0;
      if (bus_wr && (bus_addr == `GPPC_OFS_PARAM)) begin
        param_r <= bus_wdata;
      end
      if (cmd_wr) begin
        resp_r <= {!cmd_good, `GPPC_LEN_NONE, reply_type}; // RL13 RL15
      end
    end
  end

  // ==========================================
  // per-pin configuration, boot store and pad drive
  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      wire sel = (arg_idx == 8'(i));
      wire user = fm_r[i][`GPPC_FM_FUNC];
      // alternate functions keep the pad when the function bit is clear
      wire drive_lvl = user ? pwm_level[i] : alt_level[i]; // RL14 RL1
      wire [4:0] pad = pad_of(fm_r[i][2:0], drive_lvl); // RL10 RL11 RL12 RL21

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          val_r[i] <= DEF_VAL[8*i +: 8]; // RL16
          fm_r[i] <= DEF_FM[8*i +: 4]; // RL16
        end else if (restore_r) begin
          val_r[i] <= boot_val_r[i]; // RL17
          fm_r[i] <= boot_fm_r[i]; // RL17
        end else if (apply && sel) begin
          val_r[i] <= arg_val;
          if (len_full) begin
            fm_r[i] <= arg_fm[3:0]; // RL22
          end
        end
      end

      // boot store models the nonvolatile copy: only power-on reloads its factory defaults
      always_ff @(posedge core_clk or posedge pwr_on_rst) begin
        if (pwr_on_rst) begin
          boot_val_r[i] <= DEF_VAL[8*i +: 8];
          boot_fm_r[i] <= DEF_FM[8*i +: 4];
        end else if (store) begin
          boot_val_r[i] <= val_r[i]; // RL17
          boot_fm_r[i] <= fm_r[i]; // RL17
        end
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= 1'b1;
          pin_pull_up[i] <= 1'b0;
          pin_pull_dn[i] <= 1'b0;
          pin_slow[i] <= 1'b0;
          pin_user[i] <= 1'b0;
        end else begin
          pin_out[i] <= pad[4];
          pin_oe_n[i] <= pad[3];
          pin_pull_up[i] <= pad[2];
          pin_pull_dn[i] <= pad[1];
          pin_slow[i] <= pad[0];
          pin_user[i] <= user;
        end
      end

      assign duty[8*i +: 8] = val_r[i];
      assign rd_pin_hit[i] = bus_rd && (bus_addr == (`GPPC_OFS_PIN0 + 8'(4 * i)));
      assign pin_word[i] = {8'h00, 4'h0, fm_r[i], val_r[i],
                            5'h00, edge_rise[i], edge_fall[i], pin_level[i]}; // RL19
    end
  endgenerate

  // ==========================================
  // submodules
  gppc_pwm u_pwm (
    .core_clk(core_clk),
    .rst(rst),
    .duty(duty),
    .pwm_level(pwm_level)
  );

  gppc_sampler #(
    .SAMPLE_CYC(SAMPLE_CYC)
  ) u_sampler (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(pin_in),
    .clr_edge(rd_pin_hit), // RL20
    .level(pin_level),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // ==========================================
  // read mux; unmapped and write-only offsets read zero
  wire [2:0] pin_sel = bus_addr[4:2] - 3'h4;
  wire pin_space = (bus_addr >= `GPPC_OFS_PIN0) &&
                   (bus_addr < (`GPPC_OFS_PIN0 + 8'(4 * NPIN))) && (bus_addr[1:0] == 2'b00);
  wire [31:0] rd_mux = (bus_addr == `GPPC_OFS_PARAM) ? param_r :
                       (bus_addr == `GPPC_OFS_RESP) ? {15'h0000, resp_r} :
                       pin_space ? pin_word[pin_sel] : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      bus_rdata <= rd_mux; // RL19
    end
  end

endmodule

/* File: gppc_port_properties.sv */
// concurrent checks on the ports of the five-pin port
`timescale 1ns/100ps
module gppc_port_chk #(
  parameter int unsigned SAMPLE_CYC = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pwr_on_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [4:0] pin_in,
  input wire logic [4:0] alt_level,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic [4:0] pin_pull_up,
  input wire logic [4:0] pin_pull_dn,
  input wire logic [4:0] pin_slow,
  input wire logic [4:0] pin_level,
  input wire logic [4:0] pin_user
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // pad encodings
  chk_pull_excl: assert property ((pin_pull_up & pin_pull_dn) == 5'h00)
    else $error("both pulls on");
  chk_drive_no_pull: assert property ((~pin_oe_n & (pin_pull_up | pin_pull_dn)) == 5'h00)
    else $error("pull while driving");
  chk_high_driven: assert property ((pin_out & pin_oe_n) == 5'h00)
    else $error("high value on a released pad");
  chk_slow_driven: assert property ((pin_slow & pin_oe_n) == 5'h00)
    else $error("slow slew on a released pad");
  // ==========
  // sampling and host access
  // only valid while SAMPLE_CYC is above eight
  chk_level_hold: assert property ($changed(pin_level) |=> $stable(pin_level) [*8])
    else $error("level resampled too soon");
  chk_rdata_cause: assert property ($changed(bus_rdata) |-> $past(bus_rd))
    else $error("read data moved without a read");
  chk_cmd_read_zero: assert property (bus_rd && (bus_addr == 8'h04 || bus_addr == 8'h0c)
    |=> bus_rdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  // a boot-store restore shows on pin_user two edges after release
  chk_user_cause: assert property ($changed(pin_user) |->
    $past(bus_wr) || $past(bus_wr, 2) || $past(rst) || $past(rst, 2) ||
    $past(rst, 3))
    else $error("function bit moved without a command");
  cover property (bus_wr && bus_addr == 8'h04);
  cover property ($rose(pin_level[1]));
  cover property ($rose(pin_user[0]));
endmodule

bind gppc_port gppc_port_chk #(.SAMPLE_CYC(SAMPLE_CYC)) i_gppc_port_chk (
  .core_clk(core_clk), .rst(rst), .pwr_on_rst(pwr_on_rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .pin_in(pin_in), .alt_level(alt_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .pin_slow(pin_slow),
  .pin_level(pin_level), .pin_user(pin_user));

/* File: gppc_pad_model.sv */
// external load on the five pads: switches, pull resistors, floating wires
`timescale 1ns/100ps
module gppc_pad_model (
  input wire logic core_clk,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic [4:0] pin_pull_up,
  input wire logic [4:0] pin_pull_dn,
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  output logic [4:0] pin_in
);
  logic flt_r = 1'b0;
  // ==========
  // wire level
  // a floating wire has no stable value, so it toggles every cycle
  always_ff @(posedge core_clk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i] || i == 4) pin_in[i] = 1'b1;
      else if (pin_pull_dn[i]) pin_in[i] = 1'b0;
      else pin_in[i] = flt_r;
    end
  end
endmodule

/* File: gppc_port_tb.sv */
// self-checking bench of the five-pin port
`timescale 1ns/100ps
module gppc_port_tb;
  localparam int unsigned SCYC = 16;
  logic core_clk = 1'b0, rst = 1'b1, pwr_on_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, d;
  logic [4:0] alt_level = 5'h00, ext_en = 5'h00, ext_val = 5'h00, pin_in, pin_out, pin_oe_n;
  logic [4:0] pin_pull_up, pin_pull_dn, pin_slow, pin_level, pin_user;
  int mismatches = 0, total_checks = 0;
  logic [4:0] pad_hi [8] = '{5'h10, 5'h10, 5'h08, 5'h0c, 5'h11, 5'h11, 5'h00, 5'h08};
  logic [4:0] pad_lo [8] = '{5'h0a, 5'h00, 5'h08, 5'h00, 5'h08, 5'h01, 5'h00, 5'h01};
  logic [11:0] defs [5] = '{12'h200, 12'h300, 12'h200, 12'h200, 12'h764};
  // length in the top byte; bad index, value, reserved bits, mode, length
  logic [31:0] bad [5] = '{32'h03020005, 32'h03026501, 32'h03100001, 32'h030e0001, 32'h040b0001};

  gppc_port #(.SAMPLE_CYC(SCYC)) i_gppc_port (.core_clk(core_clk), .rst(rst),
    .pwr_on_rst(pwr_on_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_in(pin_in), .alt_level(alt_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_pull_dn(pin_pull_dn), .pin_slow(pin_slow), .pin_level(pin_level), .pin_user(pin_user));
  gppc_pad_model i_gppc_pad_model (.core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ==========
  // access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic cmd(input logic [31:0] p);
    wr(8'h00, {8'h00, p[23:0]});
    wr(8'h04, {16'h0000, p[31:24], 8'h22});
    rd(8'h08);
  endtask
  task automatic cfg(input logic [7:0] a, input logic [11:0] e);
    rd(a);
    check(d & 32'h000fff00, {12'h000, e, 8'h00});
  endtask
  task automatic pad(input logic [4:0] e);
    repeat (3) @(posedge core_clk);
    #1 check({27'h0, pin_out[0], pin_oe_n[0], pin_pull_up[0], pin_pull_dn[0], pin_slow[0]},
      {27'h0, e});
  endtask
  task automatic sw(input logic v);
    @(posedge core_clk);
    // an open switch lets go of the pin, so only the pull decides the level
    ext_en <= v ? 5'h00 : 5'h02;
    ext_val <= 5'h00;
    repeat (4 * SCYC) @(posedge core_clk);
  endtask
  task automatic reset_dut(input logic por);
    @(posedge core_clk);
    rst <= 1'b1;
    pwr_on_rst <= por;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    pwr_on_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    reset_dut(1'b1);
    for (int i = 0; i < 5; i++) begin
      cfg(8'h10 + 8'(4 * i), defs[i]);
    end
    check({27'h0, pin_user}, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    check(d, 32'h0);
    rd(8'h04);
    check(d, 32'h0);
    cmd(32'h030b3201);
    check(d, 32'h00000062);
    check({31'h0, pin_user[1]}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      cmd(bad[i]);
      check(d, 32'h000100e2);
      cfg(8'h14, 12'hb32);
    end
    cmd(32'h02006401);
    check(d, 32'h00000062);
    cfg(8'h14, 12'hb64);
    sw(1'b0);
    rd(8'h14);
    check(d & 32'h1, 32'h0);
    sw(1'b1);
    rd(8'h14);
    check(d & 32'h7, 32'h5);
    check({31'h0, pin_level[1]}, 32'h1);
    rd(8'h14);
    check(d & 32'h7, 32'h1);
    sw(1'b0);
    sw(1'b1);
    rd(8'h14);
    check(d & 32'h7, 32'h7);
    for (int m = 0; m < 8; m++) begin
      if (m != 6) begin
        cmd({8'h03, 5'h01, 3'(m), 16'h6400});
        pad(pad_hi[m]);
        cmd(32'h02000000);
        pad(pad_lo[m]);
      end
    end
    cmd(32'h03010000);
    @(posedge core_clk);
    alt_level <= 5'h01;
    pad(5'h10);
    @(posedge core_clk);
    alt_level <= 5'h00;
    pad(5'h00);
    wr(8'h04, 32'h00000004);
    rd(8'h08);
    check(d, 32'h00000044);
    reset_dut(1'b0);
    cfg(8'h14, 12'hb64);
    reset_dut(1'b1);
    cfg(8'h14, 12'h300);
    // one percent duty: high for the first phase after reset, low after it
    cmd(32'h03090100);
    check(d, 32'h00000062);
    pad(5'h10);
    repeat (4000) @(posedge core_clk);
    pad(5'h00);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
endmodule
